// ===== common/fsc_map.svh
// Offsets, fields, reset values and timing counts of the flash sequencer.
// Assumes a 20 MHz system clock and one AHB-Lite word per register.
`ifndef FSC_MAP_SVH
`define FSC_MAP_SVH
`define FSC_OFF_UNLOCK 8'h00
`define FSC_OFF_CTRL 8'h04
`define FSC_OFF_SEC_HI 8'h08
`define FSC_OFF_SEC_LO 8'h0C
`define FSC_OFF_ST_ADDR 8'h10
`define FSC_OFF_ST_DATA 8'h14
`define FSC_UNLOCK_KEY 8'hA5
`define FSC_RESET_BYTE 8'h00
`define FSC_CMD_ERASE 4'hA
`define FSC_CMD_PROG 4'h5
`define FSC_CC_START 0
`define FSC_CC_FAIL 3
`define FSC_ERASED 8'hFF
`define FSC_SECTOR_COUNT 128
`define FSC_SECTOR_BYTES 128
`define FSC_ERASE_TIME_US 10000
`define FSC_CLK_KHZ 20000
`define FSC_VEC_PLAIN 16'h0000
`define FSC_VEC_NONE 16'h0100
`define FSC_VEC_S0 16'h0200
`define FSC_VEC_S1 16'h0300
`define FSC_VEC_S2 16'h0500
`define FSC_VEC_S3 16'h0900
`define FSC_BOOT_BASE 16'h0100
`define FSC_PROT_S0 16'h01FF
`define FSC_PROT_S1 16'h02FF
`define FSC_PROT_S2 16'h04FF
`define FSC_PROT_S3 16'h08FF
`endif

// ===== common/fsc_pkg.sv
// Types shared by the flash sequencer modules.
// Assumes nothing of its surroundings.
package fsc_pkg;
  typedef enum logic [1:0]
  {
    st_idle   = 2'b00,
    st_erase  = 2'b01,
    st_finish = 2'b11
  } fsc_state_t;
  typedef logic [7:0] fsc_byte_t;
endpackage

// ===== core/fsc_flash_mem.sv
// Byte-wide flash array with sector erase and a registered read port.
// Assumes writes and erases never come in the same cycle.
`include "fsc_map.svh"
module fsc_flash_mem #(
  parameter int ADDR_W = 14,
  parameter int OFF_W  = 7
) (
  // Clock and reset
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  // Byte write and sector erase
  input  wire logic                    wr_en,
  input  wire logic [ADDR_W-1:0]       wr_addr,
  input  wire fsc_pkg::fsc_byte_t      wr_data,
  input  wire logic                    er_en,
  input  wire logic [ADDR_W-OFF_W-1:0] er_sector,
  // Read port
  input  wire logic [ADDR_W-1:0]       rd_addr,
  output fsc_pkg::fsc_byte_t           rd_data
);
  fsc_pkg::fsc_byte_t mem [2**ADDR_W];

  // Programming can only clear bits, as in real flash cells.
  always_ff @(posedge hclk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= mem[wr_addr] & wr_data;
    end
    else if (er_en)
    begin
      for (int i = 0; i < 2**OFF_W; i++)
      begin
        mem[{er_sector, OFF_W'(i)}] <= `FSC_ERASED;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_data <= `FSC_RESET_BYTE;
    end
    else
    begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// ===== core/fsc_boot_opt.sv
// Catches the boot option byte after reset and decodes vector and area.
// Assumes the option straps are stable from reset release on.
`include "fsc_map.svh"
module fsc_boot_opt (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Option straps
  input  wire logic [7:0]  option_byte,
  input  wire logic        boot_area_on,
  input  wire logic        vector_sel_on,
  // Decoded options
  output logic      [15:0] reset_vector,
  output logic             prot_on,
  output logic      [15:0] prot_last
);
  logic taken;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      taken        <= 1'b0;
      reset_vector <= `FSC_VEC_PLAIN;
      prot_on      <= 1'b0;
      prot_last    <= `FSC_PROT_S0;
    end
    else if (!taken)
    begin
      taken   <= 1'b1;
      prot_on <= boot_area_on & ~option_byte[2];
      case (option_byte[1:0])
        2'b00:   prot_last <= `FSC_PROT_S0;
        2'b01:   prot_last <= `FSC_PROT_S1;
        2'b10:   prot_last <= `FSC_PROT_S2;
        default: prot_last <= `FSC_PROT_S3;
      endcase
      if (!(boot_area_on && vector_sel_on))
        reset_vector <= `FSC_VEC_PLAIN;
      else if (option_byte[7])
        reset_vector <= `FSC_VEC_NONE;
      else
        case (option_byte[6:5])
          2'b00:   reset_vector <= `FSC_VEC_S0;
          2'b01:   reset_vector <= `FSC_VEC_S1;
          2'b10:   reset_vector <= `FSC_VEC_S2;
          default: reset_vector <= `FSC_VEC_S3;
        endcase
    end
  end

  vec_none_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(taken) && $past(boot_area_on && vector_sel_on && option_byte[7])
    |-> reset_vector == `FSC_VEC_NONE)
    else $error("Boot vector wrong for option 1xx.");
  vec_indep_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(taken) && $past(boot_area_on && vector_sel_on && option_byte[7:5] == 3'b010)
    |-> reset_vector == `FSC_VEC_S2)
    else $error("Boot vector depends on area size bits.");
endmodule

// ===== core/fsc_ctrl.sv
// Flash erase and program sequencer with an AHB-Lite register slave.
// Assumes a single AHB-Lite master and word-sized single transfers.
//
// Implementation choices: the AHB-Lite register port and the register offsets.
`include "fsc_map.svh"
module fsc_ctrl #(
  parameter int SECTOR_COUNT = `FSC_SECTOR_COUNT,
  parameter int SECTOR_BYTES = `FSC_SECTOR_BYTES,
  parameter int ERASE_CYCLES = `FSC_ERASE_TIME_US * `FSC_CLK_KHZ / 1000
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Device straps and events
  input  wire logic [7:0]  option_byte,
  input  wire logic        boot_area_on,
  input  wire logic        vector_sel_on,
  input  wire logic        tool_mode,
  input  wire logic        irq_pending,
  // Status
  output logic      [15:0] reset_vector,
  output logic             erase_busy,
  output logic             user_mode
);
  localparam int OFF_W  = $clog2(SECTOR_BYTES);
  localparam int SEC_W  = $clog2(SECTOR_COUNT);
  localparam int ADDR_W = OFF_W + SEC_W;
  localparam int CNT_W  = $clog2(ERASE_CYCLES + 1);

  generate
    if (2**OFF_W != SECTOR_BYTES || 2**SEC_W != SECTOR_COUNT
        || ADDR_W > 16 || OFF_W < 1 || SEC_W < 1 || ERASE_CYCLES < 1)
    begin : g_bad
      $error("Sector geometry or erase count not supported.");
    end
  endgenerate

  fsc_pkg::fsc_state_t state;
  logic               wr_pend;
  logic [7:0]         wr_addr;
  logic [1:0]         rd_wait;
  logic [31:0]        rd_word;
  fsc_pkg::fsc_byte_t key;
  logic [3:0]         cmd_mode;
  fsc_pkg::fsc_byte_t sec_hi;
  fsc_pkg::fsc_byte_t sec_lo;
  logic [15:0]        st_addr;
  logic [CNT_W-1:0]   cnt;
  logic [SEC_W-1:0]   erase_sec;
  logic               fail_flag;
  logic               prot_on;
  logic [15:0]        prot_last;
  fsc_pkg::fsc_byte_t mem_rdata;
  logic               take;
  logic               start_req;
  logic               prog_req;
  logic               mem_erase;
  logic [31:0]        busy_len;

  // Sector index of a byte address.
  function automatic logic [SEC_W-1:0] sector_of(input logic [15:0] a);
    logic [15:0] s;
    s = a >> OFF_W;
    return s[SEC_W-1:0];
  endfunction

  // True when an address lies in the protected boot area.
  function automatic logic is_prot(input logic [15:0] a, input logic on,
                                   input logic [15:0] last);
    return on && a >= `FSC_BOOT_BASE && a <= last;
  endfunction

  assign take      = hsel & hready & htrans[1];
  assign mem_erase = state == fsc_pkg::st_finish;

  assign start_req = wr_pend && wr_addr == `FSC_OFF_CTRL
                     && hwdata[`FSC_CC_START]
                     && hwdata[7:4] == `FSC_CMD_ERASE
                     && user_mode && !tool_mode
                     && state == fsc_pkg::st_idle
                     && !is_prot(16'({sector_of({sec_hi, sec_lo}), OFF_W'(0)}),
                                 prot_on, prot_last);

  assign prog_req = wr_pend && wr_addr == `FSC_OFF_ST_DATA
                    && user_mode && cmd_mode == `FSC_CMD_PROG
                    && state == fsc_pkg::st_idle
                    && (st_addr >> ADDR_W) == 16'h0000
                    && sector_of(st_addr) == sector_of({sec_hi, sec_lo})
                    && !is_prot(st_addr, prot_on, prot_last);

  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (haddr[7:0])
      `FSC_OFF_UNLOCK:  rd_word[7:0] = key;
      `FSC_OFF_CTRL:    rd_word[7:0] = {cmd_mode, fail_flag, 2'b00, erase_busy};
      `FSC_OFF_SEC_HI:  rd_word[7:0] = sec_hi;
      `FSC_OFF_SEC_LO:  rd_word[7:0] = sec_lo;
      `FSC_OFF_ST_ADDR: rd_word[15:0] = st_addr;
      default:          rd_word = 32'h0000_0000;
    endcase
  end

  // Captures the address phase of each write.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else
    begin
      wr_pend <= take & hwrite;
      if (take)
      begin
        wr_addr <= haddr[7:0];
      end
    end
  end

  // Read data; flash data reads wait two cycles for the array.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      rd_wait   <= 2'b00;
    end
    else if (rd_wait != 2'b00)
    begin
      rd_wait <= rd_wait - 2'b01;
      if (rd_wait == 2'b01)
      begin
        hrdata    <= {24'h00_0000, mem_rdata};
        hreadyout <= 1'b1;
      end
    end
    else if (take && !hwrite && haddr[7:0] == `FSC_OFF_ST_DATA)
    begin
      hreadyout <= 1'b0;
      rd_wait   <= 2'b10;
    end
    else if (take && !hwrite)
    begin
      hrdata <= rd_word;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      key       <= `FSC_RESET_BYTE;
      user_mode <= 1'b0;
    end
    else if (wr_pend && wr_addr == `FSC_OFF_UNLOCK)
    begin
      key       <= hwdata[7:0];
      user_mode <= hwdata[7:0] == `FSC_UNLOCK_KEY;
    end
  end

  // Command mode, sector address and store address.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cmd_mode <= 4'h0;
      sec_hi   <= `FSC_RESET_BYTE;
      sec_lo   <= `FSC_RESET_BYTE;
      st_addr  <= 16'h0000;
    end
    else if (wr_pend)
    begin
      case (wr_addr)
        `FSC_OFF_CTRL:    cmd_mode <= hwdata[7:4];
        `FSC_OFF_SEC_HI:  sec_hi <= hwdata[7:0];
        `FSC_OFF_SEC_LO:  sec_lo <= hwdata[7:0];
        `FSC_OFF_ST_ADDR: st_addr <= hwdata[15:0];
        default:          cmd_mode <= cmd_mode;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state      <= fsc_pkg::st_idle;
      cnt        <= '0;
      erase_sec  <= '0;
      erase_busy <= 1'b0;
    end
    else
    begin
      case (state)
        fsc_pkg::st_idle:
        begin
          if (start_req)
          begin
            state      <= fsc_pkg::st_erase;
            cnt        <= CNT_W'(ERASE_CYCLES - 1);
            erase_sec  <= sector_of({sec_hi, sec_lo});
            erase_busy <= 1'b1;
          end
        end
        fsc_pkg::st_erase:
        begin
          if (irq_pending)
          begin
            state      <= fsc_pkg::st_idle;
            erase_busy <= 1'b0;
          end
          else if (cnt == '0)
          begin
            state <= fsc_pkg::st_finish;
          end
          else
          begin
            cnt <= cnt - CNT_W'(1);
          end
        end
        fsc_pkg::st_finish:
        begin
          state      <= fsc_pkg::st_idle;
          erase_busy <= 1'b0;
        end
        default:
        begin
          state      <= fsc_pkg::st_idle;
          erase_busy <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fail_flag <= 1'b0;
    end
    else if (state == fsc_pkg::st_erase && irq_pending)
    begin
      fail_flag <= 1'b1;
    end
    else if (start_req || mem_erase)
    begin
      fail_flag <= 1'b0;
    end
  end

  fsc_flash_mem #(
    .ADDR_W (ADDR_W),
    .OFF_W  (OFF_W)
  ) u_mem (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .wr_en     (prog_req),
    .wr_addr   (st_addr[ADDR_W-1:0]),
    .wr_data   (hwdata[7:0]),
    .er_en     (mem_erase),
    .er_sector (erase_sec),
    .rd_addr   (st_addr[ADDR_W-1:0]),
    .rd_data   (mem_rdata)
  );

  fsc_boot_opt u_boot (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .option_byte   (option_byte),
    .boot_area_on  (boot_area_on),
    .vector_sel_on (vector_sel_on),
    .reset_vector  (reset_vector),
    .prot_on       (prot_on),
    .prot_last     (prot_last)
  );

  // Counts cycles of the running erase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      busy_len <= 32'h0000_0000;
    else if (start_req)
      busy_len <= 32'h0000_0001;
    else if (erase_busy)
      busy_len <= busy_len + 32'h0000_0001;
  end

  erase_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(erase_busy) |-> $past(user_mode) && $past(hwdata[7:4]) == `FSC_CMD_ERASE)
    else $error("Erase started outside user mode.");
  erase_time_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(erase_busy) && !fail_flag |-> busy_len > ERASE_CYCLES)
    else $error("Erase finished too early.");
  tool_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(erase_busy) |-> !$past(tool_mode))
    else $error("Erase started in tool mode.");
  abort_fail_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state == fsc_pkg::st_erase && irq_pending |=> !erase_busy && fail_flag)
    else $error("Interrupt did not abort erase.");
  status_ok_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state == fsc_pkg::st_finish |=> !fail_flag && !erase_busy)
    else $error("Completed erase shows failure.");
  key_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
    user_mode == (key == `FSC_UNLOCK_KEY))
    else $error("User mode disagrees with unlock key.");
  locked_ignore_a: assert property (@(posedge hclk) disable iff (!hresetn)
    prog_req || start_req |-> key == `FSC_UNLOCK_KEY)
    else $error("Command taken while locked.");
  prot_refuse_a: assert property (@(posedge hclk) disable iff (!hresetn)
    prog_req |-> !is_prot(st_addr, prot_on, prot_last))
    else $error("Store reached protected boot area.");
  erase_prot_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(erase_busy) |-> !is_prot(16'({erase_sec, OFF_W'(0)}), prot_on, prot_last))
    else $error("Erase reached protected boot area.");
endmodule

// ===== bench/fsc_cpu_model.sv
// AHB-Lite master that stands in for the firmware running on the CPU core.
// Assumes one slave whose hreadyout is fed back as hready on the main clock.
`include "fsc_map.svh"
module fsc_cpu_model (
  // Clock
  input  wire logic        hclk,
  // AHB-Lite master
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // One single word transfer, entered just after a rising edge.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    hsize <= 3'h2;
    do @(posedge hclk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'h1);
    rd = hrdata;
    hwdata <= ~wd;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] r;
    xfer(1'h1, a, {16'h0, d}, r);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    xfer(1'h0, a, 32'h0, r);
  endtask

  task automatic nop(input int k);
    repeat (k) @(posedge hclk);
  endtask

  task automatic erase(input logic [15:0] a);
    wr(`FSC_OFF_UNLOCK, {8'h0, `FSC_UNLOCK_KEY});
    wr(`FSC_OFF_SEC_HI, {8'h0, a[15:8]});
    wr(`FSC_OFF_SEC_LO, {8'h0, a[7:0]});
    wr(`FSC_OFF_CTRL, 16'h00A1);
    nop(2);
    wr(`FSC_OFF_UNLOCK, 16'h0);
  endtask

  task automatic prog(input logic [15:0] s, input logic [15:0] a, input logic [7:0] d);
    wr(`FSC_OFF_UNLOCK, {8'h0, `FSC_UNLOCK_KEY});
    wr(`FSC_OFF_CTRL, 16'h0051);
    wr(`FSC_OFF_SEC_HI, {8'h0, s[15:8]});
    wr(`FSC_OFF_SEC_LO, {8'h0, s[7:0]});
    wr(`FSC_OFF_ST_ADDR, a);
    wr(`FSC_OFF_ST_DATA, {8'h0, d});
    nop(1);
    wr(`FSC_OFF_UNLOCK, 16'h0);
  endtask

  task automatic peek(input logic [15:0] a, output logic [7:0] d);
    logic [31:0] r;
    wr(`FSC_OFF_ST_ADDR, a);
    rd(`FSC_OFF_ST_DATA, r);
    d = r[7:0];
  endtask
endmodule

// ===== bench/test_flash_sector_erase_program_ctrl.sv
// Self-checking bench for the flash sequencer driven by a firmware bus model.
// Assumes the sequencer, its header and the bus master model are compiled first.
`include "fsc_map.svh"
module test_flash_sector_erase_program_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ERASE_N = 20;
  logic        hclk, hresetn, hready, hsel, hwrite, hresp, boot_on, vsel_on;
  logic        tool_mode, irq_pending, erase_busy, user_mode;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  option_byte;
  logic [15:0] reset_vector;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          busy_run = 0;
  int          last_run = 0;

  fsc_ctrl #(.ERASE_CYCLES(ERASE_N)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .option_byte(option_byte), .boot_area_on(boot_on),
    .vector_sel_on(vsel_on), .tool_mode(tool_mode), .irq_pending(irq_pending),
    .reset_vector(reset_vector), .erase_busy(erase_busy), .user_mode(user_mode));

  fsc_cpu_model cpu (
    .hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  initial
  begin
    hclk = 1'h0;
    forever #25 hclk = ~hclk;
  end

  // Measures how many cycles each erase stays busy.
  always @(posedge hclk)
    if (erase_busy === 1'h1)
      busy_run <= busy_run + 1;
    else if (busy_run != 0)
    begin
      last_run <= busy_run;
      busy_run <= 0;
    end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("compared %0d, mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  function automatic logic [15:0] exp_vec(input logic [7:0] o, input logic en);
    if (!en)
      return `FSC_VEC_PLAIN;
    if (o[7])
      return `FSC_VEC_NONE;
    case (o[6:5])
      2'h0: return `FSC_VEC_S0;
      2'h1: return `FSC_VEC_S1;
      2'h2: return `FSC_VEC_S2;
      default: return `FSC_VEC_S3;
    endcase
  endfunction

  task automatic do_reset();
    hresetn <= 1'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do @(posedge hclk); while (erase_busy !== 1'h0 && ++n < 200);
    @(posedge hclk);
  endtask

  initial
  begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    complete_run();
  end

  initial
  begin
    logic [31:0] r;
    logic [15:0] a;
    logic [7:0]  b;
    logic [7:0]  d;
    void'($urandom(91365));
    hresetn = 1'h0;
    option_byte = 8'($urandom);
    boot_on = 1'h0;
    vsel_on = 1'h0;
    tool_mode = 1'h0;
    irq_pending = 1'h0;
    do_reset();
    cpu.rd(`FSC_OFF_UNLOCK, r);
    chk(r, 32'h0);
    chk(32'(hresp), 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      d = 8'($urandom);
      d = (d == `FSC_UNLOCK_KEY) ? 8'h5A : d;
      tool_mode <= 1'($urandom);
      irq_pending <= 1'($urandom);
      cpu.wr(`FSC_OFF_UNLOCK, {8'h0, d});
      cpu.nop(1);
      chk(32'(user_mode), 32'h0);
    end
    tool_mode <= 1'h0;
    irq_pending <= 1'h0;
    cpu.wr(`FSC_OFF_UNLOCK, {8'h0, `FSC_UNLOCK_KEY});
    cpu.nop(1);
    chk(32'(user_mode), 32'h1);
    cpu.wr(`FSC_OFF_UNLOCK, 16'h0);
    cpu.nop(1);
    chk(32'(user_mode), 32'h0);
    cpu.rd(8'h20, r);
    chk(r, 32'h0);
    cpu.wr(`FSC_OFF_CTRL, 16'h00A1);
    cpu.nop(2);
    chk(32'(erase_busy), 32'h0);
    $display("unlock test done");
    cpu.erase(16'h1000);
    wait_idle();
    chk(32'(last_run), 32'(ERASE_N + 1));
    cpu.rd(`FSC_OFF_CTRL, r);
    chk(32'(r[3:0]), 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      a = 16'h1000 + 16'(i * 32) + ((i == 3) ? 16'h1F : 16'($urandom % 32));
      d = 8'($urandom);
      cpu.prog(16'h1000, a, d);
      cpu.peek(a, b);
      chk(32'(b), 32'(d));
    end
    cpu.erase(16'h1080);
    wait_idle();
    cpu.peek(16'h107F, b);
    chk(32'(b), 32'(d));
    cpu.peek(16'h1080, b);
    chk(32'(b), 32'(`FSC_ERASED));
    cpu.wr(`FSC_OFF_CTRL, 16'h0051);
    cpu.wr(`FSC_OFF_ST_ADDR, 16'h1090);
    cpu.wr(`FSC_OFF_ST_DATA, 16'h0);
    cpu.peek(16'h1090, b);
    chk(32'(b), 32'(`FSC_ERASED));
    $display("erase and program test done");
    tool_mode <= 1'h1;
    cpu.erase(16'h1000);
    chk(32'(erase_busy), 32'h0);
    wait_idle();
    cpu.peek(16'h107F, b);
    chk(32'(b), 32'(d));
    tool_mode <= 1'h0;
    cpu.erase(16'h1080);
    irq_pending <= 1'h1;
    cpu.nop(2);
    chk(32'(erase_busy), 32'h0);
    irq_pending <= 1'h0;
    cpu.rd(`FSC_OFF_CTRL, r);
    chk(32'(r[3]), 32'h1);
    cpu.erase(16'h1080);
    wait_idle();
    cpu.rd(`FSC_OFF_CTRL, r);
    chk(32'(r[3]), 32'h0);
    $display("abort test done");
    cpu.erase(16'h0100);
    wait_idle();
    d = 8'($urandom) | 8'h01;
    cpu.prog(16'h0100, 16'h0105, d);
    boot_on <= 1'h1;
    option_byte <= 8'h00;
    do_reset();
    cpu.prog(16'h0100, 16'h0105, 8'h00);
    cpu.erase(16'h0100);
    wait_idle();
    cpu.peek(16'h0105, b);
    chk(32'(b), 32'(d));
    $display("protected area test done");
    for (int i = 0; i < 6; i++)
    begin
      b = 8'($urandom);
      b[7:5] = (i < 4) ? {1'h0, 2'(i)} : {1'h1, b[6:5]};
      option_byte <= b;
      vsel_on <= (i != 5);
      boot_on <= (i != 4);
      do_reset();
      cpu.nop(1);
      chk(32'(reset_vector), 32'(exp_vec(b, i < 4)));
    end
    $display("reset vector test done");
    complete_run();
  end
endmodule
